/* File: ria_defines.svh */
// Constants of the interval, divided-clock, alarm and correction block.
// Assumes a 20 MHz ref_clk and a 32.768 kHz subsystem clock on a pin.
`ifndef RIA_DEFINES_SVH
`define RIA_DEFINES_SVH

// --------------------------------------------------------------
// Register indices; byte address is four times the index.
// --------------------------------------------------------------
`define RIA_IDX_CTRL 18'h0FF6F
`define RIA_IDX_ALM_MIN 18'h0FF70
`define RIA_IDX_ALM_HOUR 18'h0FF71
`define RIA_IDX_ALM_WDAY 18'h0FF72
`define RIA_IDX_CORR 18'h0FF73
`define RIA_IDX_AUX 18'h0FF74
`define RIA_IDX_STAT 18'h0FF75
`define RIA_IDX_MASK 18'h0FF76

// --------------------------------------------------------------
// Field positions and reset values.
// --------------------------------------------------------------
`define RIA_CTRL_INT_EN 7
`define RIA_CTRL_OUT_EN_B 6
`define RIA_CTRL_FREQ_SEL 5
`define RIA_CTRL_WMASK 8'hE7
`define RIA_CTRL_RESET 8'h00
`define RIA_CORR_RESET 8'h00
`define RIA_AUX_ALARM_EN 0
`define RIA_AUX_OUT_EN_A 1
`define RIA_STAT_INTV 0
`define RIA_STAT_FIXED 1
`define RIA_STAT_ALARM 2

// --------------------------------------------------------------
// Timing constants: subsystem clock counts, divider bit positions and second numbers.
// --------------------------------------------------------------
`define RIA_SEC_TICKS 17'h08000
`define RIA_HALF_SEC 17'h04000
`define RIA_INTV_BASE 6
`define RIA_INTV_MAX_N 3'h6
`define RIA_DIV_SLOW_BIT 5
`define RIA_DIV_FAST_BIT 0
`define RIA_CORR_SEC_A 6'h00
`define RIA_CORR_SEC_B 6'h14
`define RIA_CORR_SEC_C 6'h28
`define RIA_LAST_SEC 6'h3B

`endif

/* File: ria_divout.sv */
// Interval interrupt generator and divided-clock pin driver.
// Assumes fsubTick is a one-cycle pulse per rising subsystem clock edge.
`timescale 1ns/100ps
`include "ria_defines.svh"
module ria_divout (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // Settings
  input wire logic fsubTick,
  input wire logic intEn,
  input wire logic [2:0] intSel,
  input wire logic outEn,
  input wire logic freqSel,
  // Results
  output logic intvPulse,
  output logic divPin
);
  import ria_pkg::*;

  logic [11:0] cnt_r, cnt_nxt;
  logic pulse_r, pulse_nxt;
  logic pin_r, pin_nxt;
  logic [2:0] n;
  logic [11:0] mask;

  assign intvPulse = pulse_r;
  assign divPin = pin_r;

  always_comb begin
    n = (intSel > `RIA_INTV_MAX_N) ? `RIA_INTV_MAX_N : intSel;
    mask = 12'(({12'h000, 1'b1} << (`RIA_INTV_BASE + n)) - 13'h0001);
    cnt_nxt = fsubTick ? cnt_r + 12'h001 : cnt_r;
    pulse_nxt = fsubTick && intEn && ((cnt_nxt & mask) == 12'h000);
    pin_nxt = pin_r;
    if (fsubTick) begin
      if (!outEn) begin
        // A high phase just begun is cut at the next edge, which is the
        // short final pulse a stop may leave behind.
        pin_nxt = 1'b0;
      end else if (freqSel) begin
        pin_nxt = cnt_nxt[`RIA_DIV_FAST_BIT];
      end else begin
        pin_nxt = cnt_nxt[`RIA_DIV_SLOW_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 12'h000;
      pulse_r <= 1'b0;
      pin_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
      pin_r <= pin_nxt;
    end
  end

  a_pin_stays_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && !outEn && !pin_r |=> !pin_r)
    else $error("Disabled divided clock pin rose.");

  a_pin_settles: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && !outEn && fsubTick |=> !pin_r)
    else $error("Disabled divided clock pin did not settle low.");

  a_slow_freq: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && outEn && !freqSel && fsubTick |=> pin_r == cnt_r[5])
    else $error("512 Hz output does not follow its divider tap.");

endmodule // ria_divout

/* File: ria_pkg.sv */
// Types shared by the interval, divided-clock, alarm and correction block.
// Assumes the constants header is compiled alongside.
package ria_pkg;

  typedef enum logic {RIA_IDLE, RIA_ANSWER} ria_apb_st_t;

  typedef struct packed {
    logic dev;
    logic sign;
    logic [5:0] count;
  } ria_corr_t;

  typedef struct packed {
    logic [7:0] minute;
    logic [7:0] hour;
    logic [6:0] wday;
  } ria_time_t;

endpackage

/* File: ria_timebase.sv */
// Subsystem clock synchroniser, corrected second divider and 1 Hz output.
// Assumes the subsystem clock pin is far slower than ref_clk.
`timescale 1ns/100ps
`include "ria_defines.svh"
module ria_timebase (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // Pin and correction setting
  input wire logic subClkPin,
  input wire ria_pkg::ria_corr_t corr,
  // Time base
  output logic fsubTick,
  output logic oneHz,
  output logic clk32k
);
  import ria_pkg::*;

  logic [2:0] sync_r, sync_nxt;
  logic [16:0] subCnt_r, subCnt_nxt;
  logic [5:0] sec_r, sec_nxt;
  logic oneHz_r, oneHz_nxt;
  logic signed [8:0] corrVal;
  logic corrSec;
  logic [16:0] period;

  assign fsubTick = sync_r[1] & ~sync_r[2];
  assign oneHz = oneHz_r;
  assign clk32k = sync_r[1];

  always_comb begin
    sync_nxt = {sync_r[1:0], subClkPin};
    corrVal = 9'sh000;
    if (corr.sign) begin
      corrVal = -$signed({2'b00, ~corr.count, 1'b0}) - 9'sh002;
    end else if (corr.count > 6'h01) begin
      corrVal = $signed({2'b00, corr.count - 6'h01, 1'b0});
    end
    if (corr.dev) begin
      corrSec = (sec_r == `RIA_CORR_SEC_A);
    end else begin
      corrSec = (sec_r == `RIA_CORR_SEC_A) || (sec_r == `RIA_CORR_SEC_B) ||
        (sec_r == `RIA_CORR_SEC_C);
    end
    period = `RIA_SEC_TICKS;
    if (corrSec) begin
      period = `RIA_SEC_TICKS + 17'(corrVal);
    end
    subCnt_nxt = subCnt_r;
    sec_nxt = sec_r;
    if (fsubTick) begin
      if (subCnt_r >= period - 17'h00001) begin
        subCnt_nxt = 17'h00000;
        sec_nxt = (sec_r == `RIA_LAST_SEC) ? 6'h00 : sec_r + 6'h01;
      end else begin
        subCnt_nxt = subCnt_r + 17'h00001;
      end
    end
    oneHz_nxt = (subCnt_nxt < `RIA_HALF_SEC);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_r <= 3'h0;
      subCnt_r <= 17'h00000;
      sec_r <= 6'h00;
      oneHz_r <= 1'b0;
    end else if (ce) begin
      sync_r <= sync_nxt;
      subCnt_r <= subCnt_nxt;
      sec_r <= sec_nxt;
      oneHz_r <= oneHz_nxt;
    end
  end

  a_zero_corr: assert property (@(posedge ref_clk) disable iff (!resetn)
    (corr == ria_corr_t'(`RIA_CORR_RESET)) |-> period == `RIA_SEC_TICKS)
    else $error("Zero correction register changed the second length.");

endmodule // ria_timebase

/* File: ria_top.sv */
// Interval, divided-clock, alarm and correction block with an APB slave.
// Assumes the calendar counter sits outside and supplies the current time
// and a one-cycle fixed-cycle event, both on ref_clk.
`timescale 1ns/100ps
`include "ria_defines.svh"
module ria_top (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Calendar side
  input wire ria_pkg::ria_time_t curTime,
  input wire logic fixedCycleEvt,
  // Pins
  input wire logic subClkPin,
  output logic dividedClockPin,
  output logic clk32kOutputPin,
  output logic oneHzOutputPin,
  // Interrupts
  output logic intervalIrq,
  output logic rtcSharedIrq,
  output logic irq
);
  import ria_pkg::*;

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  ria_apb_st_t st_r, st_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] almMin_r, almMin_nxt;
  logic [7:0] almHour_r, almHour_nxt;
  logic [6:0] almWday_r, almWday_nxt;
  ria_corr_t corr_r, corr_nxt;
  logic [1:0] aux_r, aux_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [2:0] mask_r, mask_nxt;

  // --------------------------------------------------------------
  // Event state
  // --------------------------------------------------------------
  logic match_r, match_nxt;
  logic intvIrq_r, intvIrq_nxt;
  logic sharedIrq_r, sharedIrq_nxt;
  logic irq_r, irq_nxt;
  logic clk32k_r, clk32k_nxt;

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  logic [17:0] idx;
  logic aligned;
  logic hitCtrl, hitMin, hitHour, hitWday;
  logic hitCorr, hitAux, hitStat, hitMask;
  logic hit;
  logic wrEn;
  logic [7:0] wb;
  logic [31:0] rdMux;
  logic matchNow;
  logic alarmEvt;
  logic [2:0] setBits;
  logic [2:0] clrBits;

  // --------------------------------------------------------------
  // Sub-blocks
  // --------------------------------------------------------------
  logic fsubTick;
  logic oneHz;
  logic clk32kRaw;
  logic intvPulse;
  logic divPin;

  ria_timebase u_timebase (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .subClkPin(subClkPin),
    .corr(corr_r),
    .fsubTick(fsubTick),
    .oneHz(oneHz),
    .clk32k(clk32kRaw)
  );

  ria_divout u_divout (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .fsubTick(fsubTick),
    .intEn(ctrl_r[`RIA_CTRL_INT_EN]),
    .intSel(ctrl_r[2:0]),
    .outEn(ctrl_r[`RIA_CTRL_OUT_EN_B]),
    .freqSel(ctrl_r[`RIA_CTRL_FREQ_SEL]),
    .intvPulse(intvPulse),
    .divPin(divPin)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dividedClockPin = divPin;
  assign clk32kOutputPin = clk32k_r;
  assign oneHzOutputPin = oneHz;
  assign intervalIrq = intvIrq_r;
  assign rtcSharedIrq = sharedIrq_r;
  assign irq = irq_r;

  // --------------------------------------------------------------
  // Address decode and read mux
  // --------------------------------------------------------------
  always_comb begin
    idx = paddr[19:2];
    aligned = (paddr[1:0] == 2'b00);
    hitCtrl = aligned && (idx == `RIA_IDX_CTRL);
    hitMin = aligned && (idx == `RIA_IDX_ALM_MIN);
    hitHour = aligned && (idx == `RIA_IDX_ALM_HOUR);
    hitWday = aligned && (idx == `RIA_IDX_ALM_WDAY);
    hitCorr = aligned && (idx == `RIA_IDX_CORR);
    hitAux = aligned && (idx == `RIA_IDX_AUX);
    hitStat = aligned && (idx == `RIA_IDX_STAT);
    hitMask = aligned && (idx == `RIA_IDX_MASK);
    hit = hitCtrl | hitMin | hitHour | hitWday | hitCorr | hitAux |
      hitStat | hitMask;
    rdMux = 32'h00000000;
    if (hitCtrl) begin
      rdMux = {24'h000000, ctrl_r};
    end
    if (hitMin) begin
      rdMux = {24'h000000, almMin_r};
    end
    if (hitHour) begin
      rdMux = {24'h000000, almHour_r};
    end
    if (hitWday) begin
      rdMux = {25'h0, almWday_r};
    end
    if (hitCorr) begin
      rdMux = {24'h000000, corr_r};
    end
    if (hitAux) begin
      rdMux = {30'h0, aux_r};
    end
    if (hitStat) begin
      rdMux = {29'h0, stat_r};
    end
    if (hitMask) begin
      rdMux = {29'h0, mask_r};
    end
  end

  // --------------------------------------------------------------
  // APB handshake
  // --------------------------------------------------------------
  // The answer is always one wait state long, so the read mux is
  // sampled once and held steady while pready is high.
  always_comb begin
    st_nxt = st_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    unique case (st_r)
      RIA_IDLE: begin
        if (psel && penable) begin
          st_nxt = RIA_ANSWER;
          pready_nxt = 1'b1;
          pslverr_nxt = !hit;
          prdata_nxt = (pwrite || !hit) ? 32'h00000000 : rdMux;
        end
      end
      RIA_ANSWER: begin
        st_nxt = RIA_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= RIA_IDLE;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // --------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------
  always_comb begin
    wrEn = (st_r == RIA_ANSWER) && psel && penable && pwrite && pstrb[0];
    wb = pwdata[7:0];
    ctrl_nxt = ctrl_r;
    almMin_nxt = almMin_r;
    almHour_nxt = almHour_r;
    almWday_nxt = almWday_r;
    corr_nxt = corr_r;
    aux_nxt = aux_r;
    mask_nxt = mask_r;
    clrBits = 3'h0;
    if (wrEn) begin
      if (hitCtrl) begin
        ctrl_nxt = wb & `RIA_CTRL_WMASK;
      end
      // Each alarm field loads on its own, so the order of the three
      // writes never matters once all have landed.
      if (hitMin) begin
        almMin_nxt = wb;
      end
      if (hitHour) begin
        almHour_nxt = wb;
      end
      if (hitWday) begin
        almWday_nxt = wb[6:0];
      end
      if (hitCorr) begin
        corr_nxt = ria_corr_t'(wb);
      end
      if (hitAux) begin
        aux_nxt = wb[1:0];
      end
      if (hitStat) begin
        clrBits = wb[2:0];
      end
      if (hitMask) begin
        mask_nxt = wb[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `RIA_CTRL_RESET;
      almMin_r <= 8'h00;
      almHour_r <= 8'h00;
      almWday_r <= 7'h00;
      corr_r <= ria_corr_t'(`RIA_CORR_RESET);
      aux_r <= 2'h0;
      mask_r <= 3'h0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      almMin_r <= almMin_nxt;
      almHour_r <= almHour_nxt;
      almWday_r <= almWday_nxt;
      corr_r <= corr_nxt;
      aux_r <= aux_nxt;
      mask_r <= mask_nxt;
    end
  end

  // --------------------------------------------------------------
  // Alarm match, events and interrupts
  // --------------------------------------------------------------
  // Only a rising match counts, so a standing match after the flag is
  // cleared does not refire until the match falls and rises again.
  always_comb begin
    matchNow = aux_r[`RIA_AUX_ALARM_EN] &&
      (curTime.minute == almMin_r) && (curTime.hour == almHour_r) &&
      ((curTime.wday & almWday_r) != 7'h00);
    match_nxt = matchNow;
    alarmEvt = matchNow && !match_r;
    setBits = 3'h0;
    setBits[`RIA_STAT_INTV] = intvPulse;
    setBits[`RIA_STAT_FIXED] = fixedCycleEvt;
    setBits[`RIA_STAT_ALARM] = alarmEvt;
    stat_nxt = (stat_r & ~clrBits) | setBits;
    intvIrq_nxt = intvPulse;
    sharedIrq_nxt = fixedCycleEvt | alarmEvt;
    irq_nxt = |(stat_nxt & mask_nxt);
    clk32k_nxt = aux_r[`RIA_AUX_OUT_EN_A] & clk32kRaw;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stat_r <= 3'h0;
      match_r <= 1'b0;
      intvIrq_r <= 1'b0;
      sharedIrq_r <= 1'b0;
      irq_r <= 1'b0;
      clk32k_r <= 1'b0;
    end else if (ce) begin
      stat_r <= stat_nxt;
      match_r <= match_nxt;
      intvIrq_r <= intvIrq_nxt;
      sharedIrq_r <= sharedIrq_nxt;
      irq_r <= irq_nxt;
      clk32k_r <= clk32k_nxt;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_alarm_flag_held;
    ce && stat_r[`RIA_STAT_ALARM] &&
      !(wrEn && hitStat && wb[`RIA_STAT_ALARM]);
  endsequence

  a_interval_gated: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && $rose(intvIrq_r) |-> $past(ctrl_r[`RIA_CTRL_INT_EN], 2))
    else $error("Interval interrupt fired while disabled.");

  a_ctrl_reserved: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrEn && hitCtrl && ce |=> ctrl_r[4:3] == 2'b00)
    else $error("Reserved control bits did not read zero.");

  a_shared_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && sharedIrq_r |-> stat_r[2] || stat_r[1])
    else $error("Shared interrupt without a status flag.");

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_alarm_flag_held |=> stat_r[`RIA_STAT_ALARM])
    else $error("Alarm flag dropped without a clear.");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce |=> irq_r == |(stat_r & mask_r))
    else $error("Interrupt output does not track masked status.");

endmodule // ria_top

/* File: tb_top.sv */
// Self-checking bench for the interval, divided-clock, alarm and correction
// block. Assumes the design files and the constants header are compiled first.
`timescale 1ns/100ps
`include "ria_defines.svh"
module tb_top;
  import ria_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk, resetn, ce, psel, penable, pwrite;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic pready, pslverr, fixedCycleEvt, subClkPin, err;
  ria_time_t curTime;
  logic dividedClockPin, clk32kOutputPin, oneHzOutputPin;
  logic intervalIrq, rtcSharedIrq, irq;
  int errors, checkCount, subRises, seed, n;
  logic [17:0] alIdx [3];
  logic [31:0] alVal [3];
  int codes [5];

  ria_top DUT (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .curTime(curTime), .fixedCycleEvt(fixedCycleEvt),
    .subClkPin(subClkPin), .dividedClockPin(dividedClockPin),
    .clk32kOutputPin(clk32kOutputPin), .oneHzOutputPin(oneHzOutputPin),
    .intervalIrq(intervalIrq), .rtcSharedIrq(rtcSharedIrq), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // The subclock runs at six ref cycles a period instead of the real rate,
  // so long interval codes fit in the run; gap counts are in subclock rising edges.
  initial begin
    subClkPin = 1'b0;
    forever begin
      repeat (3) @(posedge ref_clk);
      subClkPin <= ~subClkPin;
    end
  end

  always @(posedge subClkPin) subRises <= subRises + 1;

  // ----------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------
  function automatic logic [19:0] ad(input logic [17:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic int ivPeriod(input int c);
    return 1 << (`RIA_INTV_BASE + ((c > 6) ? 6 : c));
  endfunction

  function automatic logic sig(input int k);
    return (k == 0) ? intervalIrq : dividedClockPin;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [19:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [17:0] i, input logic [31:0] d);
    apb(1'b1, ad(i), d, 4'hF);
  endtask

  task automatic rd(input logic [17:0] i);
    apb(1'b0, ad(i), 32'h0, 4'h0);
  endtask

  // Subclock rising edges between two rising edges of the chosen output.
  task automatic gap(input int k, output int d);
    int s, c;
    logic p;
    s = 0;
    for (int i = 0; i < 2; i++) begin
      c = 0;
      p = 1'b1;
      while (!(sig(k) === 1'b1 && p === 1'b0) && c < 60000) begin
        p = sig(k);
        @(posedge ref_clk);
        c++;
      end
      if (i == 0) s = subRises;
    end
    d = subRises - s;
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 20'h00000; pwdata = 32'h0; pstrb = 4'h0; fixedCycleEvt = 1'b0;
    curTime = '0; errors = 0; checkCount = 0; subRises = 0;
    seed = 32'h40DE123A;
    codes = '{0, 1, 2, 3, 7};
    alIdx = '{`RIA_IDX_ALM_MIN, `RIA_IDX_ALM_HOUR, `RIA_IDX_ALM_WDAY};
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (logic [17:0] i = `RIA_IDX_CTRL; i <= `RIA_IDX_MASK; i++) begin
      rd(i);
      check("reset value", rdv, 32'h0);
    end
    apb(1'b0, ad(18'h0FF80), 32'h0, 4'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rdv, 32'h0);
    $display("Test registers reset done");

    // Enable stays clear so the select field never moves while enabled.
    for (int i = 0; i < 12; i++) begin
      logic [31:0] d, m;
      logic [3:0] s;
      d = (i == 0) ? 32'h7F : ($random(seed) & 32'h7F);
      s = (i == 1 || ($random(seed) & 1)) ? 4'hE : 4'hF;
      rd(`RIA_IDX_CTRL);
      m = s[0] ? (d & 32'h000000E7) : rdv;
      apb(1'b1, ad(`RIA_IDX_CTRL), d, s);
      rd(`RIA_IDX_CTRL);
      check("control readback", rdv, m);
    end
    for (int i = 0; i < 6; i++) begin
      alVal[0] = (i == 0) ? 32'h2C : ($random(seed) & 32'hFF);
      wr(`RIA_IDX_CORR, alVal[0]);
      rd(`RIA_IDX_CORR);
      check("correction readback", rdv, alVal[0]);
    end
    wr(`RIA_IDX_CORR, 32'h0);
    $display("Test register access done");

    wr(`RIA_IDX_CTRL, 32'h0);
    n = 0;
    repeat (2400) begin
      @(posedge ref_clk);
      if (intervalIrq !== 1'b0) n++;
    end
    check("interval while disabled", n, 0);
    for (int i = 0; i < 5; i++) begin
      wr(`RIA_IDX_CTRL, codes[i]);
      wr(`RIA_IDX_CTRL, 32'h80 | codes[i]);
      gap(0, n);
      check("interval period", n, ivPeriod(codes[i]));
      @(posedge ref_clk);
      check("interval pulse", intervalIrq, 1'b0);
      wr(`RIA_IDX_CTRL, codes[i]);
    end
    rd(`RIA_IDX_STAT);
    check("interval status", rdv & 32'h1, 32'h1);
    wr(`RIA_IDX_STAT, 32'h1);
    wr(`RIA_IDX_CTRL, 32'h0);
    $display("Test interval done");

    wr(`RIA_IDX_CTRL, 32'h60);
    gap(1, n);
    check("fast divided period", n, 2);
    wr(`RIA_IDX_CTRL, 32'h40);
    // The first rise after a switch can fall mid-phase, so skip one gap.
    repeat (2) gap(1, n);
    check("slow divided period", n, 64);
    wr(`RIA_IDX_CTRL, 32'h0);
    repeat (12) @(posedge ref_clk);
    n = 0;
    repeat (600) begin
      @(posedge ref_clk);
      if (dividedClockPin !== 1'b0) n++;
    end
    check("divided pin stopped", n, 0);
    $display("Test divided clock done");

    wr(`RIA_IDX_MASK, 32'h7);
    fixedCycleEvt <= 1'b1;
    @(posedge ref_clk);
    fixedCycleEvt <= 1'b0;
    @(posedge ref_clk);
    check("fixed shared irq", rtcSharedIrq, 1'b1);
    check("fixed irq level", irq, 1'b1);
    @(posedge ref_clk);
    check("fixed irq pulse", rtcSharedIrq, 1'b0);
    rd(`RIA_IDX_STAT);
    check("fixed status", rdv, 32'h2);
    wr(`RIA_IDX_STAT, 32'h2);
    rd(`RIA_IDX_STAT);
    check("status cleared", rdv, 32'h0);
    check("irq cleared", irq, 1'b0);
    for (int o = 0; o < 2; o++) begin
      alVal[0] = $random(seed) & 32'h3F;
      alVal[1] = $random(seed) & 32'h1F;
      alVal[2] = 32'h1 << o;
      curTime <= '{alVal[0][7:0] + 8'h1, alVal[1][7:0], alVal[2][6:0]};
      wr(`RIA_IDX_MASK, o ? 32'h0 : 32'h7);
      wr(`RIA_IDX_AUX, 32'h0);
      for (int j = 0; j < 3; j++) begin
        wr(alIdx[o ? 2 - j : j], alVal[o ? 2 - j : j]);
      end
      wr(`RIA_IDX_AUX, 32'h1);
      curTime <= '{alVal[0][7:0], alVal[1][7:0], alVal[2][6:0]};
      n = 0;
      repeat (5) begin
        @(posedge ref_clk);
        if (rtcSharedIrq === 1'b1) n++;
      end
      check("alarm shared irq", n, 1);
      check("alarm irq masking", irq, o ? 1'b0 : 1'b1);
      rd(`RIA_IDX_STAT);
      check("alarm status", rdv, 32'h4);
      wr(`RIA_IDX_STAT, 32'h4);
      wr(`RIA_IDX_AUX, 32'h0);
    end
    $display("Test shared interrupt done");

    // The divided pin is off here, so the 32 kHz output may be enabled.
    wr(`RIA_IDX_AUX, 32'h2);
    n = 0;
    repeat (60) begin
      @(posedge ref_clk);
      if (clk32kOutputPin === 1'b1) n++;
    end
    check("32k output duty", n, 30);
    check("1 Hz output level", oneHzOutputPin, 1'b1);
    ce <= 1'b0;
    @(posedge ref_clk);
    rdv = {31'h0, clk32kOutputPin};
    n = 0;
    repeat (12) begin
      @(posedge ref_clk);
      if (clk32kOutputPin !== rdv[0]) n++;
    end
    check("frozen while disabled", n, 0);
    ce <= 1'b1;
    $display("Test reference outputs done");
    print_verdict();
  end
endmodule // tb_top
